// File: ebrw_ext_mem.sv
`timescale 1ns/1ps
// ============================================================================
// External memory with a ready output held low for a set delay
module ebrw_ext_mem (
  input  wire logic        hclk,
  input  wire logic [2:0]  zone_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        read_write_dir,
  input  wire logic [18:0] ext_addr,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_data_oe,
  input  wire logic [7:0]  ready_delay,
  output logic             ext_ready_in,
  output logic [15:0]      ext_data_in
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;
  int          cnt;

  always @(posedge hclk) begin
    cnt <= (&zone_select_n) ? 0 : cnt + 1;
    last_q <= ext_data_in;
    if (!write_strobe_n && read_write_dir === 1'b0 && ext_data_oe === 1'b1) begin
      mem[ext_addr[7:0]] <= ext_data_out;
    end
  end

  // Ready stays low until the part has waited long enough
  assign ext_ready_in = (&zone_select_n) ? 1'b0 : (cnt >= int'(ready_delay));
  // Undriven bus shows a changing pattern so stale data cannot pass
  assign ext_data_in = !read_strobe_n ? mem[ext_addr[7:0]] : ~last_q;
endmodule : ebrw_ext_mem

// File: ebrw_pkg.sv
package ebrw_pkg;

  // ==========================================================================
  // Register map (byte offsets)
  localparam logic [7:0] EBRW_OFF_CTRL   = 8'h00;
  localparam logic [7:0] EBRW_OFF_TIMING = 8'h04;
  localparam logic [7:0] EBRW_OFF_ADDR   = 8'h08;
  localparam logic [7:0] EBRW_OFF_WDATA  = 8'h0C;
  localparam logic [7:0] EBRW_OFF_CMD    = 8'h10;
  localparam logic [7:0] EBRW_OFF_STATUS = 8'h14;
  localparam logic [7:0] EBRW_OFF_RDATA  = 8'h18;

  // ==========================================================================
  // Control and command fields
  localparam int EBRW_CTRL_USE_RDY  = 0;
  localparam int EBRW_CTRL_ASYNC    = 1;
  localparam int EBRW_CTRL_DOUBLER  = 2;
  localparam int EBRW_CTRL_ZONE_LSB = 4;
  localparam int EBRW_CMD_WRITE     = 0;

  // Timing fields: each count is 4 bits
  localparam int EBRW_T_RD_LEAD  = 0;
  localparam int EBRW_T_RD_ACT   = 4;
  localparam int EBRW_T_RD_TRAIL = 8;
  localparam int EBRW_T_WR_LEAD  = 12;
  localparam int EBRW_T_WR_ACT   = 16;
  localparam int EBRW_T_WR_TRAIL = 20;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] EBRW_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EBRW_TIMING_RST = 32'h0013_1131;

  // Cycles of asynchronous ready look-ahead
  localparam logic [5:0] EBRW_ASYNC_EARLY = 6'h02;

  typedef enum logic [2:0] {
    EBRW_IDLE  = 3'b000,
    EBRW_ALIGN = 3'b001,
    EBRW_LEAD  = 3'b010,
    EBRW_ACT   = 3'b011,
    EBRW_TRAIL = 3'b100
  } ebrw_state_t;

endpackage : ebrw_pkg

// File: ebrw_rdysmp.sv
`timescale 1ns/1ps
// ============================================================================
// First-sample point and ready decision
module ebrw_rdysmp (
  input  wire logic       use_rdy,
  input  wire logic       async_mode,
  input  wire logic [4:0] lead_act,
  input  wire logic [5:0] elapsed,
  input  wire logic       rdy,
  output logic            sample_now,
  output logic            hold_wait
);
  logic [5:0] first_pt;
  logic [5:0] la6;

  assign la6 = {1'b0, lead_act};
  // Async ready is looked at two timing cycles earlier
  assign first_pt   = async_mode ? (la6 - ebrw_pkg::EBRW_ASYNC_EARLY) : la6;
  assign sample_now = use_rdy && (elapsed >= first_pt);
  assign hold_wait  = sample_now && !rdy;

endmodule : ebrw_rdysmp

// File: ebrw_tick.sv
`timescale 1ns/1ps
// ============================================================================
// Timing clock and bus output clock phase generator
module ebrw_tick (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic doubler,
  output logic      tim_tick,
  output logic      bus_clk_out,
  output logic      bus_rise_next
);
  logic tim_q;
  logic bclk_q;

  // Timing clock enable every second hclk; bus clock is half of that if doubled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tim_q  <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      tim_q <= ~tim_q;
      if (tim_q) begin
        bclk_q <= doubler ? ~bclk_q : 1'b0;
      end
    end
  end

  assign tim_tick      = tim_q;
  // Phase runs one hclk ahead of the pin, which is registered in the top
  assign bus_clk_out   = doubler ? ~bclk_q : ~tim_q;
  // Next timing tick starts a bus clock high phase
  assign bus_rise_next = doubler ? bclk_q : 1'b1;

endmodule : ebrw_tick

// File: ebrw_top.sv
`timescale 1ns/1ps
module ebrw_top #(
  parameter int AW = 19,
  parameter int DW = 16,
  parameter int ZN = 3
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          ext_ready_in,
  input  wire logic [DW-1:0] ext_data_in,
  output logic               bus_clock_out,
  output logic [AW-1:0]      ext_addr,
  output logic [DW-1:0]      ext_data_out,
  output logic               ext_data_oe,
  output logic               write_strobe_n,
  output logic               read_strobe_n,
  output logic               read_write_dir,
  output logic [ZN-1:0]      zone_select_n
);

  // ==========================================================================
  // Bus slave
  logic [31:0] ctrl_q, timing_q, addr_q, wdata_q, rdata_q, hrdata_q;
  logic        wr_pend_q, rd_pend_q;
  logic [7:0]  a_off_q;
  logic        busy_q, go_q, go_wr_q;
  logic        hreadyout_q;
  logic        done_pulse;
  logic        accept;
  logic        mapped;
  logic [7:0]  off;
  logic        fwd_hit;
  logic        busy_rd;

  assign accept = hsel && htrans[1] && hready;
  assign off    = haddr[7:0];
  assign mapped = (off <= ebrw_pkg::EBRW_OFF_RDATA) && (off[1:0] == 2'b00);
  // A write still in its data phase to the register being read is forwarded
  assign fwd_hit = wr_pend_q && !busy_q && (a_off_q == off)
                && (off < ebrw_pkg::EBRW_OFF_CMD);
  // A command that has not yet raised busy already reads as busy
  assign busy_rd = busy_q || go_q || (wr_pend_q && (a_off_q == ebrw_pkg::EBRW_OFF_CMD));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      a_off_q   <= 8'h00;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      if (accept) begin
        a_off_q <= off;
      end
    end
  end

  // Register writes land in the data phase; always zero wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= ebrw_pkg::EBRW_CTRL_RST;
      timing_q <= ebrw_pkg::EBRW_TIMING_RST;
      addr_q   <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
      go_q     <= 1'b0;
      go_wr_q  <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_pend_q && !busy_q) begin
        case (a_off_q)
          ebrw_pkg::EBRW_OFF_CTRL:   ctrl_q   <= hwdata;
          ebrw_pkg::EBRW_OFF_TIMING: timing_q <= hwdata;
          ebrw_pkg::EBRW_OFF_ADDR:   addr_q   <= hwdata;
          ebrw_pkg::EBRW_OFF_WDATA:  wdata_q  <= hwdata;
          ebrw_pkg::EBRW_OFF_CMD: begin
            go_q    <= 1'b1;
            go_wr_q <= hwdata[ebrw_pkg::EBRW_CMD_WRITE];
          end
          default: ;
        endcase
      end
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux = !mapped ? 32'h0000_0000 :
    (off == ebrw_pkg::EBRW_OFF_CTRL)   ? ctrl_q :
    (off == ebrw_pkg::EBRW_OFF_TIMING) ? timing_q :
    (off == ebrw_pkg::EBRW_OFF_ADDR)   ? addr_q :
    (off == ebrw_pkg::EBRW_OFF_WDATA)  ? wdata_q :
    (off == ebrw_pkg::EBRW_OFF_STATUS) ? {31'h0000_0000, busy_rd} :
    (off == ebrw_pkg::EBRW_OFF_RDATA)  ? rdata_q : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
      // Captured at the address phase so the data phase sees a flop
      if (accept && !hwrite) begin
        hrdata_q <= fwd_hit ? hwdata : rd_mux;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  // ==========================================================================
  // Timing clock and sampling helpers
  logic tim_tick, bclk, bus_rise_next;

  ebrw_tick u_tick (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .doubler       (ctrl_q[ebrw_pkg::EBRW_CTRL_DOUBLER]),
    .tim_tick      (tim_tick),
    .bus_clk_out   (bclk),
    .bus_rise_next (bus_rise_next)
  );

  ebrw_pkg::ebrw_state_t st_q;
  logic [3:0] cnt_q;
  logic [5:0] elapsed_q;
  logic       wr_q;
  logic [3:0] lead_c, act_c, trail_c;
  logic       sample_now, hold_wait;

  assign lead_c  = wr_q ? timing_q[ebrw_pkg::EBRW_T_WR_LEAD +: 4]
                        : timing_q[ebrw_pkg::EBRW_T_RD_LEAD +: 4];
  assign act_c   = wr_q ? timing_q[ebrw_pkg::EBRW_T_WR_ACT +: 4]
                        : timing_q[ebrw_pkg::EBRW_T_RD_ACT +: 4];
  assign trail_c = wr_q ? timing_q[ebrw_pkg::EBRW_T_WR_TRAIL +: 4]
                        : timing_q[ebrw_pkg::EBRW_T_RD_TRAIL +: 4];

  ebrw_rdysmp u_rdy (
    .use_rdy    (ctrl_q[ebrw_pkg::EBRW_CTRL_USE_RDY]),
    .async_mode (ctrl_q[ebrw_pkg::EBRW_CTRL_ASYNC]),
    .lead_act   ({1'b0, lead_c} + {1'b0, act_c}),
    .elapsed    (elapsed_q),
    .rdy        (ext_ready_in),
    .sample_now (sample_now),
    .hold_wait  (hold_wait)
  );

  // ==========================================================================
  // Access sequencer, advances once per timing clock tick
  logic act_end;
  assign act_end = (cnt_q <= 4'h1) && !hold_wait;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= ebrw_pkg::EBRW_IDLE;
      cnt_q     <= 4'h0;
      elapsed_q <= 6'h00;
      wr_q      <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      if (go_q) begin
        busy_q <= 1'b1;
        wr_q   <= go_wr_q;
        st_q   <= ebrw_pkg::EBRW_ALIGN;
      end else if (tim_tick) begin
        case (st_q)
          ebrw_pkg::EBRW_ALIGN: begin
            // Wait out alignment until the next tick is a bus clock rise
            if (bus_rise_next) begin
              st_q      <= ebrw_pkg::EBRW_LEAD;
              cnt_q     <= (lead_c == 4'h0) ? 4'h1 : lead_c;
              elapsed_q <= 6'h01;
            end
          end
          ebrw_pkg::EBRW_LEAD: begin
            elapsed_q <= elapsed_q + 6'h01;
            if (cnt_q <= 4'h1) begin
              st_q  <= ebrw_pkg::EBRW_ACT;
              cnt_q <= act_c;
            end else begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
          ebrw_pkg::EBRW_ACT: begin
            if (elapsed_q != 6'h3F) begin
              elapsed_q <= elapsed_q + 6'h01;
            end
            if (act_end) begin
              st_q  <= ebrw_pkg::EBRW_TRAIL;
              cnt_q <= trail_c;
            end else if (cnt_q > 4'h1 && !hold_wait) begin
              // A low ready sample freezes the count: one tick per low sample
              cnt_q <= cnt_q - 4'h1;
            end
          end
          ebrw_pkg::EBRW_TRAIL: begin
            if (cnt_q <= 4'h1) begin
              st_q   <= ebrw_pkg::EBRW_IDLE;
              busy_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
          default: st_q <= ebrw_pkg::EBRW_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Pin registers
  logic in_acc;
  assign in_acc = (st_q == ebrw_pkg::EBRW_LEAD) || (st_q == ebrw_pkg::EBRW_ACT)
               || (st_q == ebrw_pkg::EBRW_TRAIL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_clock_out  <= 1'b0;
      ext_addr       <= '0;
      ext_data_out   <= '0;
      ext_data_oe    <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      read_write_dir <= 1'b1;
      zone_select_n  <= '1;
      rdata_q        <= 32'h0000_0000;
    end else begin
      bus_clock_out <= bclk;
      // Address changes only when a new access begins
      if (in_acc) begin
        ext_addr <= addr_q[AW-1:0];
      end
      zone_select_n  <= in_acc ? ~(ZN'(1) << ctrl_q[ebrw_pkg::EBRW_CTRL_ZONE_LSB +: 2])
                               : '1;
      read_write_dir <= !(in_acc && wr_q);
      write_strobe_n <= !(wr_q && st_q == ebrw_pkg::EBRW_ACT);
      read_strobe_n  <= !(!wr_q && st_q == ebrw_pkg::EBRW_ACT);
      // Data enabled with the strobe, kept through trail, and released only once
      // dir has been seen high, so after the strobe the bus never floats while dir is still low
      ext_data_oe    <= wr_q && ((st_q == ebrw_pkg::EBRW_ACT) ||
                        (st_q == ebrw_pkg::EBRW_TRAIL) ||
                        (ext_data_oe && !read_write_dir));
      ext_data_out   <= wdata_q[DW-1:0];
      if (!wr_q && st_q == ebrw_pkg::EBRW_ACT && act_end && tim_tick) begin
        rdata_q <= {{(32-DW){1'b0}}, ext_data_in};
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_align_idle;
    @(posedge hclk) disable iff (!hresetn)
      (st_q == ebrw_pkg::EBRW_ALIGN) |=> (write_strobe_n && zone_select_n == '1);
  endproperty
  a_align_idle: assert property (p_align_idle) else $error("strobe in alignment");

  property p_addr_hold;
    @(posedge hclk) disable iff (!hresetn)
      !in_acc |=> $stable(ext_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved when idle");

  property p_wait;
    @(posedge hclk) disable iff (!hresetn)
      (tim_tick && st_q == ebrw_pkg::EBRW_ACT && hold_wait) |=> st_q == ebrw_pkg::EBRW_ACT;
  endproperty
  a_wait: assert property (p_wait) else $error("ready low not honoured");

  property p_ready_done;
    @(posedge hclk) disable iff (!hresetn)
      (tim_tick && st_q == ebrw_pkg::EBRW_ACT && sample_now && ext_ready_in
       && cnt_q <= 4'h1) |=> st_q == ebrw_pkg::EBRW_TRAIL;
  endproperty
  a_ready_done: assert property (p_ready_done) else $error("ready high did not end");

  property p_dir_write;
    @(posedge hclk) disable iff (!hresetn)
      !write_strobe_n |-> (!read_write_dir && !ext_data_oe == 1'b0);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("dir or data off in write");

  property p_release;
    @(posedge hclk) disable iff (!hresetn)
      $rose(read_write_dir) |-> ext_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("data freed before dir high");

  property p_zone_dir;
    @(posedge hclk) disable iff (!hresetn)
      (!read_write_dir) |-> (zone_select_n != '1);
  endproperty
  a_zone_dir: assert property (p_zone_dir) else $error("write without zone select");

  property p_no_rdy;
    @(posedge hclk) disable iff (!hresetn)
      (tim_tick && st_q == ebrw_pkg::EBRW_ACT && !ctrl_q[ebrw_pkg::EBRW_CTRL_USE_RDY]
       && cnt_q <= 4'h1) |=> st_q == ebrw_pkg::EBRW_TRAIL;
  endproperty
  a_no_rdy: assert property (p_no_rdy) else $error("ready used while off");

  c_write: cover property (@(posedge hclk) $fell(write_strobe_n));
  c_read:  cover property (@(posedge hclk) $fell(read_strobe_n));
  c_wait:  cover property (@(posedge hclk) tim_tick && hold_wait);

endmodule : ebrw_top

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int L = 2;
  localparam int A = 3;
  localparam logic [31:0] TIM = 32'h0013_2132;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, zsn, zone_seen, zone_p;
  logic [15:0] din, dout;
  logic [18:0] xaddr, addr_p;
  logic        bclk, oe, wsn, rsn, dir, oe_p, dir_p, sl_p, dir_low;
  logic [7:0]  rdy_dly;
  int          slen, bad_count, n_checks;

  assign hready = hreadyout;

  ebrw_top u_ebrw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_ready_in(rdy),
    .ext_data_in(din), .bus_clock_out(bclk), .ext_addr(xaddr), .ext_data_out(dout),
    .ext_data_oe(oe), .write_strobe_n(wsn), .read_strobe_n(rsn),
    .read_write_dir(dir), .zone_select_n(zsn));

  ebrw_ext_mem u_ebrw_ext_mem (.hclk(hclk), .zone_select_n(zsn), .write_strobe_n(wsn),
    .read_strobe_n(rsn), .read_write_dir(dir), .ext_addr(xaddr), .ext_data_out(dout),
    .ext_data_oe(oe), .ready_delay(rdy_dly), .ext_ready_in(rdy), .ext_data_in(din));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Pin monitor: stays on every cycle so short glitches are seen too
  always @(posedge hclk) begin
    if (hresetn) begin
      if (oe && !oe_p) chk("oe_after_strobe", {31'h0, wsn}, 32'h0);
      if (!oe && oe_p) chk("dir_before_release", {31'h0, dir_p}, 32'h1);
      if (&zsn && &zone_p) chk("addr_hold", {13'h0, xaddr}, {13'h0, addr_p});
      if (!(&zsn) && &zone_p) begin
        chk("bus_clk_at_select", {31'h0, bclk}, 32'h1);
        zone_seen = zsn;
      end
      if (!wsn && dir === 1'b0) dir_low = 1'b1;
      if (!wsn || !rsn) slen = sl_p ? slen + 1 : 1;
    end
    oe_p = oe;
    dir_p = dir;
    zone_p = zsn;
    addr_p = xaddr;
    sl_p = !wsn || !rsn;
  end

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wait_idle;
    logic [31:0] r;
    int n;
    r = 32'h1;
    n = 0;
    while (r[0] !== 1'b0 && n < 200) begin
      ahb(1'b0, ebrw_pkg::EBRW_OFF_STATUS, 32'h0, r);
      n++;
    end
    chk("busy_clears", {31'h0, r[0]}, 32'h0);
  endtask : wait_idle

  // Strobe width in hclk: one extra timing tick for each low ready sample
  function automatic int exp_len(input logic [2:0] m, input int dly);
    int t, n;
    // Ready is looked at one hclk before the pin point, as the strobe is registered
    t = 2 * (L + A - 1) - (m[1] ? 4 : 0);
    n = 0;
    if (m[0]) while (t + 2 * n < dly) n++;
    return 2 * (A + n);
  endfunction : exp_len

  task automatic access(input logic wr, input logic [1:0] z, input logic [2:0] m,
                        input logic [7:0] dly, input logic [18:0] a, input logic [15:0] d);
    logic [31:0] r;
    rdy_dly <= dly;
    dir_low = 1'b0;
    ahb(1'b1, ebrw_pkg::EBRW_OFF_CTRL, {26'h0, z, 1'b0, m}, r);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_ADDR, {13'h0, a}, r);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_WDATA, {16'h0, d}, r);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_CMD, {31'h0, wr}, r);
    wait_idle();
    chk("zone_select", {29'h0, zone_seen}, {29'h0, ~(3'b001 << z)});
    if (!m[2]) chk("strobe_len", slen, exp_len(m, dly));
    if (wr) begin
      chk("dir_low", {31'h0, dir_low}, 32'h1);
      chk("mem_data", {16'h0, u_ebrw_ext_mem.mem[a[7:0]]}, {16'h0, d});
    end else begin
      ahb(1'b0, ebrw_pkg::EBRW_OFF_RDATA, 32'h0, r);
      chk("read_data", {16'h0, r[15:0]}, {16'h0, d});
    end
  endtask : access

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b0, ebrw_pkg::EBRW_OFF_CTRL, 32'h0, r);
    chk("ctrl_reset", r, ebrw_pkg::EBRW_CTRL_RST);
    ahb(1'b0, ebrw_pkg::EBRW_OFF_TIMING, 32'h0, r);
    chk("timing_reset", r, ebrw_pkg::EBRW_TIMING_RST);
    ahb(1'b1, 8'h1C, 32'hFFFF_FFFF, r);
    ahb(1'b0, 8'h1C, 32'h0, r);
    chk("unmapped", r, 32'h0);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_TIMING, TIM, r);
  endtask : t_regs

  // Mode and ready delay pairs: off, ready early in sync mode only, late in sync and async mode
  task automatic t_ready_modes(input logic wr);
    logic [2:0] m [5] = '{3'd0, 3'd1, 3'd1, 3'd3, 3'd3};
    logic [7:0] d [5] = '{8'hFF, 8'h00, 8'h0D, 8'h0D, 8'h07};
    for (int i = 0; i < 5; i++) begin
      access(wr, 2'(i % 3), m[i], d[i], 19'(16 + i), 16'(16'hA5C0 + i * 16'h0111));
    end
  endtask : t_ready_modes

  task automatic t_doubler;
    access(1'b1, 2'd1, 3'b101, 8'h0D, 19'h7FF40, 16'h3C5A);
  endtask : t_doubler

  // Timing writes are dropped while an access is running
  task automatic t_busy;
    logic [31:0] r;
    rdy_dly <= 8'h3C;
    ahb(1'b1, ebrw_pkg::EBRW_OFF_CTRL, 32'h1, r);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_CMD, 32'h1, r);
    ahb(1'b1, ebrw_pkg::EBRW_OFF_TIMING, 32'h0, r);
    wait_idle();
    ahb(1'b0, ebrw_pkg::EBRW_OFF_TIMING, 32'h0, r);
    chk("timing_kept", r, TIM);
  endtask : t_busy

  initial begin
    #(8 * 40000);
    bad_count++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rdy_dly = 8'h0;
    bad_count = 0;
    n_checks = 0;
    slen = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_ready_modes(1'b1);
    t_ready_modes(1'b0);
    t_doubler();
    t_busy();
    finish_test();
  end
endmodule : tb_top
